// ### hdl/dual_slope_pwm_timer16.sv
// Dual-slope 16-bit PWM timer with an APB register slave.
//
// Chosen here: the placing of the registers and the APB register port.
module dual_slope_pwm_timer16
   import pwm_timer_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic COMPARE_A_OUTPUT,
   output logic COMPARE_A_OE,
   output logic COMPARE_B_OUTPUT,
   output logic COMPARE_B_OE
);

   ctrl_t ctrl_ff; // Control register.
   logic [15:0] captop_ff; // Capture/top register, not buffered.
   logic [15:0] cmp_buf_ff [2]; // Compare buffers written by software.
   logic [15:0] cmp_ff [2]; // Compare values in use.
   logic [15:0] count_ff; // Counter value.
   dir_t dir_ff; // Counting direction.
   logic [9:0] presc_ff; // Prescaler counter.
   logic [3:0] flags_ff; // Sticky event flags.
   logic [31:0] prdata_ff; // Read data captured in the setup cycle.
   logic [1:0] out_ff; // Compare output levels.
   logic [9:0] presc_last; // Last prescaler count of the chosen divider.
   logic tick; // Timer clock enable.
   logic dual; // A dual-slope mode is selected.
   logic pfc; // Phase-and-frequency-correct mode is selected.
   logic fixed_top; // A fixed 8/9/10-bit TOP is selected.
   logic [15:0] top; // TOP of the current mode.
   logic at_top; // Tick while the counter stands at TOP on the up slope.
   logic at_bottom; // Tick while the counter stands at zero.
   logic [1:0] match; // Per-channel compare match on a tick.
   logic wr_en; // APB write takes effect this cycle.
   logic setup; // APB setup cycle.
   logic mapped; // Address hits a register.
   logic [3:0] mode; // Shorthand for the mode field.

   assign mode = ctrl_ff.waveform_mode_sel;
   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign PREADY = 1'b1;
   assign PRDATA = prdata_ff;

   // Address decode; every register is one aligned word.
   always_comb begin
      case (PADDR)
         OFS_CTRL, OFS_CMPA, OFS_CMPB, OFS_CAPTOP, OFS_COUNT, OFS_FLAGS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Unmapped addresses answer with an error in the access phase.
   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Mode decode.
   always_comb begin
      dual = 1'b1;
      pfc = 1'b0;
      fixed_top = 1'b0;
      top = captop_ff;
      case (mode)
         MODE_PC8: begin
            fixed_top = 1'b1; // RL2
            top = TOP_8BIT;
         end
         MODE_PC9: begin
            fixed_top = 1'b1; // RL2
            top = TOP_9BIT;
         end
         MODE_PC10: begin
            fixed_top = 1'b1; // RL2
            top = TOP_10BIT;
         end
         // Variable TOP may range from 0x0003 to 0xffff. RL11
         MODE_PC_CAP: top = captop_ff; // RL2
         MODE_PC_A: top = cmp_ff[0]; // RL2
         MODE_PFC_CAP: begin
            pfc = 1'b1; // RL16
            top = captop_ff;
         end
         MODE_PFC_A: begin
            pfc = 1'b1; // RL16
            top = cmp_ff[0];
         end
         // Other modes belong elsewhere; the counter stands still.
         default: dual = 1'b0;
      endcase
   end

   // Divider choice: 0 stops the timer, 1..5 divide by 1,8,64,256,1024.
   always_comb begin
      case (ctrl_ff.clock_sel)
         3'h2: presc_last = DIV8_LAST; // RL20
         3'h3: presc_last = DIV64_LAST; // RL20
         3'h4: presc_last = DIV256_LAST; // RL20
         3'h5: presc_last = DIV1024_LAST; // RL20
         default: presc_last = RST_PRESC;
      endcase
   end

   // The tick is a one-cycle enable on the core clock, never a clock. RL22
   assign tick = (ctrl_ff.clock_sel != 3'h0) && (ctrl_ff.clock_sel <= 3'h5)
                 && (presc_ff == presc_last); // RL20

   // Prescaler counter wraps at the last count of the divider.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         presc_ff <= RST_PRESC;
      end else if (presc_ff >= presc_last) begin
         presc_ff <= RST_PRESC;
      end else begin
         presc_ff <= presc_ff + 10'h001;
      end
   end

   // Events seen while the counter stands at a turning point.
   assign at_top = tick && dual && (dir_ff == DIR_UP) && (count_ff >= top);
   assign at_bottom = tick && dual && (count_ff == RST_WORD);

   // Up/down counter; each turning value lasts exactly one tick.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         count_ff <= RST_WORD;
         dir_ff <= DIR_UP; // RL23
      end else if (tick && dual) begin
         case (dir_ff)
            DIR_UP: begin
               if (count_ff >= top) begin
                  dir_ff <= DIR_DOWN; // RL1 RL3
                  count_ff <= count_ff - 16'h0001;
               end else begin
                  count_ff <= count_ff + 16'h0001; // RL1
               end
            end
            DIR_DOWN: begin
               if (count_ff == RST_WORD) begin
                  dir_ff <= DIR_UP; // RL23
                  count_ff <= count_ff + 16'h0001;
               end else begin
                  count_ff <= count_ff - 16'h0001; // RL1
               end
            end
            default: dir_ff <= DIR_UP;
         endcase
      end
   end

   // Control and capture/top registers written over APB.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ctrl_ff <= '0;
         captop_ff <= RST_WORD;
      end else if (wr_en) begin
         if (PADDR == OFS_CTRL) begin
            ctrl_ff <= ctrl_t'(PWDATA[13:0]);
            ctrl_ff.spare <= 1'b0;
         end
         if (PADDR == OFS_CAPTOP) begin
            captop_ff <= PWDATA[15:0];
         end
      end
   end

   // Read data is captured in the setup cycle and shown in the access phase.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         case (PADDR)
            OFS_CTRL: prdata_ff <= {18'h00000, ctrl_ff};
            OFS_CMPA: prdata_ff <= {16'h0000, cmp_buf_ff[0]};
            OFS_CMPB: prdata_ff <= {16'h0000, cmp_buf_ff[1]};
            OFS_CAPTOP: prdata_ff <= {16'h0000, captop_ff};
            OFS_COUNT: prdata_ff <= {16'h0000, count_ff};
            OFS_FLAGS: prdata_ff <= {28'h0000000, flags_ff};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // Per-channel compare buffer, compare register, match and output.
   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic [7:0] ofs; // Offset of this channel's compare register.
      logic [1:0] act; // Output action selector of this channel.
      logic rising; // Match counts as up slope; zero counts as up, TOP as down.
      logic [15:0] wmask; // Bits kept on a compare write.

      assign ofs = (i == 0) ? OFS_CMPA : OFS_CMPB;
      assign act = (i == 0) ? ctrl_ff.output_action_sel_a : ctrl_ff.output_action_sel_b;
      assign rising = (count_ff == RST_WORD) ||
                      ((dir_ff == DIR_UP) && (count_ff < top));
      assign wmask = fixed_top ? top : 16'hffff; // RL9

      // Writes go to the buffer, masked to the fixed resolution.
      always_ff @(posedge CORE_CLK or posedge RST) begin
         if (RST) begin
            cmp_buf_ff[i] <= RST_WORD;
         end else if (wr_en && (PADDR == ofs)) begin
            cmp_buf_ff[i] <= PWDATA[15:0] & wmask; // RL9
         end
      end

      // Buffer loads at TOP (phase correct) or zero (frequency correct).
      always_ff @(posedge CORE_CLK or posedge RST) begin
         if (RST) begin
            cmp_ff[i] <= RST_WORD;
         end else if (!dual) begin
            cmp_ff[i] <= cmp_buf_ff[i];
         end else if (!pfc && at_top) begin
            cmp_ff[i] <= cmp_buf_ff[i]; // RL7 RL12
         end else if (pfc && at_bottom) begin
            cmp_ff[i] <= cmp_buf_ff[i]; // RL17
         end
      end

      assign match[i] = tick && dual && (count_ff == cmp_ff[i]); // RL8

      // Output set/clear on match; a match at TOP acts as the down slope.
      always_ff @(posedge CORE_CLK or posedge RST) begin
         if (RST) begin
            out_ff[i] <= 1'b0;
         end else if (match[i]) begin
            case (act)
               ACT_NONINV: out_ff[i] <= !rising; // RL4 RL5 RL14 RL19
               ACT_INV: out_ff[i] <= rising; // RL4 RL5 RL14 RL19
               ACT_TOGGLE: begin
                  if (i == 0) begin
                     out_ff[i] <= !out_ff[i]; // RL15
                  end
               end
               default: out_ff[i] <= out_ff[i];
            endcase
         end
      end
   end

   // Sticky flags; a set in the same cycle as a write-one clear wins.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         flags_ff <= 4'h0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr_en && (PADDR == OFS_FLAGS) && PWDATA[b]) begin
               flags_ff[b] <= 1'b0;
            end
         end
         if (at_bottom) begin
            flags_ff[FLG_OVF] <= 1'b1; // RL6 RL17
         end
         if (match[0] || (at_top && (mode == MODE_PC_A || mode == MODE_PFC_A))) begin
            flags_ff[FLG_CMPA] <= 1'b1; // RL7 RL8 RL18
         end
         if (match[1]) begin
            flags_ff[FLG_CMPB] <= 1'b1; // RL8
         end
         if (at_top && (mode == MODE_PC_CAP || mode == MODE_PFC_CAP)) begin
            flags_ff[FLG_CAPT] <= 1'b1; // RL7 RL18
         end
      end
   end

   // The pin carries the level only when its direction bit says output. RL21
   assign COMPARE_A_OUTPUT = out_ff[0];
   assign COMPARE_B_OUTPUT = out_ff[1];
   assign COMPARE_A_OE = ctrl_ff.pin_direction_bit_a && (ctrl_ff.output_action_sel_a != ACT_OFF);
   assign COMPARE_B_OE = ctrl_ff.pin_direction_bit_b &&
                         (ctrl_ff.output_action_sel_b != ACT_OFF) &&
                         (ctrl_ff.output_action_sel_b != ACT_TOGGLE);

   // Checks on the counter, buffering, flags and outputs.
   sequence s_top_turn;
      at_top && (count_ff == top);
   endsequence

   sequence s_going_down;
      (dir_ff == DIR_DOWN) && (count_ff == $past(count_ff) - 16'h0001);
   endsequence

   AST_TOP_TURN: assert property (@(posedge CORE_CLK) disable iff (RST) // RL3
      s_top_turn |=> s_going_down)
      else $error("Counter did not reverse one below TOP.");

   AST_STILL_BETWEEN_TICKS: assert property (@(posedge CORE_CLK) disable iff (RST) // RL22
      !tick |=> $stable(count_ff))
      else $error("Counter moved without a tick.");

   AST_OVF_BOTTOM: assert property (@(posedge CORE_CLK) disable iff (RST) // RL6
      (tick && dual && count_ff == 16'h0000) |=> flags_ff[FLG_OVF])
      else $error("Overflow flag not set at zero.");

   AST_LOAD_TOP: assert property (@(posedge CORE_CLK) disable iff (RST) // RL7
      (at_top && !pfc) |=> (cmp_ff[1] == $past(cmp_buf_ff[1])))
      else $error("Compare B not loaded at TOP.");

   AST_LOAD_BOTTOM: assert property (@(posedge CORE_CLK) disable iff (RST) // RL17
      (at_bottom && pfc) |=> (cmp_ff[1] == $past(cmp_buf_ff[1])) && flags_ff[FLG_OVF])
      else $error("Compare B not loaded with overflow at zero.");

   AST_PFC_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST) // RL17
      (pfc && !at_bottom && !$past(!dual)) |=> $stable(cmp_ff[1]))
      else $error("Compare B changed away from zero.");

   AST_CMP_FLAG: assert property (@(posedge CORE_CLK) disable iff (RST) // RL8
      (tick && dual && count_ff == cmp_ff[1]) |=> flags_ff[FLG_CMPB])
      else $error("Compare B flag not set on match.");

   AST_CAPT_TOP: assert property (@(posedge CORE_CLK) disable iff (RST) // RL18
      (at_top && mode == MODE_PFC_CAP) |=> flags_ff[FLG_CAPT])
      else $error("Capture flag not set at TOP.");

   AST_CLEAR_UP: assert property (@(posedge CORE_CLK) disable iff (RST) // RL4
      (match[1] && ctrl_ff.output_action_sel_b == ACT_NONINV && dir_ff == DIR_UP
       && count_ff != 16'h0000 && count_ff < top) |=> !out_ff[1])
      else $error("Non-inverted output not cleared on rising match.");

   AST_MASK_WRITE: assert property (@(posedge CORE_CLK) disable iff (RST) // RL9
      (wr_en && PADDR == OFS_CMPB && mode == MODE_PC8) |=> (cmp_buf_ff[1][15:8] == 8'h00))
      else $error("Compare bits above 8-bit resolution kept.");

   AST_DIV8: assert property (@(posedge CORE_CLK) // RL20
      disable iff (RST || (wr_en && PADDR == OFS_CTRL))
      (tick && ctrl_ff.clock_sel == 3'h2 && presc_ff == 10'h007)
      |=> (!tick)[*7] ##1 tick)
      else $error("Divide-by-8 tick spacing wrong.");

   // Checks on the turn at zero, channel A loading, the outputs and the pin enable.
   sequence s_bottom_turn;
      at_bottom && (dir_ff == DIR_DOWN);
   endsequence

   sequence s_going_up;
      (dir_ff == DIR_UP) && (count_ff == 16'h0001);
   endsequence

   AST_BOTTOM_TURN: assert property (@(posedge CORE_CLK) disable iff (RST) // RL23
      s_bottom_turn |=> s_going_up)
      else $error("Counter did not reverse upward at zero.");

   AST_LOAD_A_TOP: assert property (@(posedge CORE_CLK) disable iff (RST) // RL7
      (at_top && !pfc) |=> (cmp_ff[0] == $past(cmp_buf_ff[0])))
      else $error("Compare A not loaded at TOP.");

   AST_TOP_SOURCE_FLAG: assert property (@(posedge CORE_CLK) disable iff (RST) // RL7
      (at_top && mode == MODE_PC_A) |=> flags_ff[FLG_CMPA])
      else $error("Compare A flag not set at TOP.");

   AST_CAPT_PC_TOP: assert property (@(posedge CORE_CLK) disable iff (RST) // RL7
      (at_top && mode == MODE_PC_CAP) |=> flags_ff[FLG_CAPT])
      else $error("Capture flag not set at phase-correct TOP.");

   AST_SET_DOWN: assert property (@(posedge CORE_CLK) disable iff (RST) // RL4
      (match[1] && ctrl_ff.output_action_sel_b == ACT_NONINV && dir_ff == DIR_DOWN
       && count_ff != 16'h0000) |=> out_ff[1])
      else $error("Non-inverted output not set on falling match.");

   AST_INV_CLEAR_DOWN: assert property (@(posedge CORE_CLK) disable iff (RST) // RL5
      (match[1] && ctrl_ff.output_action_sel_b == ACT_INV && dir_ff == DIR_DOWN
       && count_ff != 16'h0000) |=> !out_ff[1])
      else $error("Inverted output not cleared on falling match.");

   AST_TOGGLE_A: assert property (@(posedge CORE_CLK) disable iff (RST) // RL15
      (match[0] && ctrl_ff.output_action_sel_a == ACT_TOGGLE)
      |=> (out_ff[0] != $past(out_ff[0])))
      else $error("Channel A did not toggle on match.");

   AST_OE_DIR: assert property (@(posedge CORE_CLK) disable iff (RST) // RL21
      !ctrl_ff.pin_direction_bit_a |-> !COMPARE_A_OE)
      else $error("Channel A driver enabled with direction input.");

endmodule : dual_slope_pwm_timer16

// ### hdl/pwm_timer_pkg.sv
// Constants, types and register map of the dual-slope PWM timer.
//
// Behaviour
// [RL1] Modes 1,2,3,10,11 count up then down.
// [RL2] Phase-correct TOP: fixed, capture, or compare A.
// [RL3] Counter holds TOP one tick, then reverses.
// [RL4] Non-inverting: clear rising match, set falling.
// [RL5] Action two non-inverted, three inverted PWM.
// [RL6] Phase-correct sets overflow flag at zero.
// [RL7] Phase-correct loads compares at TOP, sets source flag.
// [RL8] Compare flag set when count equals compare.
// [RL9] Fixed TOP masks high compare bits on write.
// [RL10] Software keeps TOP above every compare value.
// [RL11] Variable TOP spans 2 to 16 bits.
// [RL12] TOP change gives asymmetric phase-correct period.
// [RL13] Software prefers frequency-correct mode when changing TOP.
// [RL14] Compare zero low, compare TOP high, phase-correct.
// [RL15] Mode 11 action 1 toggles A, 50 percent.
// [RL16] Modes 8, 9: frequency-correct, capture or A TOP.
// [RL17] Frequency-correct loads compares and overflow at zero.
// [RL18] Frequency-correct sets TOP-source flag at TOP.
// [RL19] Frequency-correct: compare zero low, TOP high.
// [RL20] Prescaler divides 1,8,64,256,1024; period 2*N*TOP.
// [RL21] Pin shows output only with direction output.
// [RL22] Synchronous counter, prescaled tick is only an enable.
// [RL23] Reset direction is up; zero reverses like TOP.
package pwm_timer_pkg;

   // Byte offsets of the APB registers.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMPA = 8'h04;
   localparam logic [7:0] OFS_CMPB = 8'h08;
   localparam logic [7:0] OFS_CAPTOP = 8'h0c;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;

   // Flag bit positions in the flag register.
   localparam int FLG_OVF = 0;
   localparam int FLG_CMPA = 1;
   localparam int FLG_CMPB = 2;
   localparam int FLG_CAPT = 3;

   // Waveform modes handled by this block.
   localparam logic [3:0] MODE_PC8 = 4'h1;
   localparam logic [3:0] MODE_PC9 = 4'h2;
   localparam logic [3:0] MODE_PC10 = 4'h3;
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PFC_A = 4'h9;
   localparam logic [3:0] MODE_PC_CAP = 4'ha;
   localparam logic [3:0] MODE_PC_A = 4'hb;

   // Fixed TOP values of the 8-, 9- and 10-bit modes.
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;

   // Output action selector codes.
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_NONINV = 2'h2;
   localparam logic [1:0] ACT_INV = 2'h3;

   // Last prescaler count for each divider (divider minus one).
   localparam logic [9:0] DIV8_LAST = 10'h007;
   localparam logic [9:0] DIV64_LAST = 10'h03f;
   localparam logic [9:0] DIV256_LAST = 10'h0ff;
   localparam logic [9:0] DIV1024_LAST = 10'h3ff;

   // Values after reset.
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [9:0] RST_PRESC = 10'h000;

   // Control register: direction bits, action selectors, prescaler, mode.
   typedef struct packed {
      logic pin_direction_bit_b;
      logic pin_direction_bit_a;
      logic [1:0] output_action_sel_b;
      logic [1:0] output_action_sel_a;
      logic spare;
      logic [2:0] clock_sel;
      logic [3:0] waveform_mode_sel;
   } ctrl_t;

   // Counting direction, one-hot.
   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } dir_t;

endpackage : pwm_timer_pkg

// ### testbench/dual_slope_pwm_timer16_bench.sv
// Self-checking bench for the dual-slope PWM timer.
module dual_slope_pwm_timer16_bench
   import pwm_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0; // System clock.
   logic rst = 1'b1; // Active-high reset.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
   logic [7:0] paddr = 8'h00; // APB address.
   logic [31:0] pwdata = 32'h0000_0000; // APB write data.
   logic [31:0] prdata; // APB read data.
   logic pready, pslverr, out_a, oe_a, out_b, oe_b, pin_a, pin_b; // Answers and pins.
   int fails = 0; // Mismatch count.
   int samples_checked = 0; // Comparison count.

   // Free-running 100 MHz clock.
   initial begin
      forever #5 core_clk = ~core_clk;
   end

   dual_slope_pwm_timer16 DUT (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COMPARE_A_OUTPUT(out_a),
      .COMPARE_A_OE(oe_a), .COMPARE_B_OUTPUT(out_b), .COMPARE_B_OE(oe_b));

   pwm_load_model LOAD (.drive_a(out_a), .oe_a(oe_a), .drive_b(out_b), .oe_b(oe_b),
      .pin_a(pin_a), .pin_b(pin_b));

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("Checked %0d values, %0d mismatches", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Compares one seen value with its expectation.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One APB transfer; the request holds until PREADY is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         fails++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   // Register read compared with an expectation.
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, exp);
   endtask : rdchk

   // Builds a control word.
   function automatic logic [31:0] ctrl(logic [3:0] m, logic [2:0] s, logic [1:0] aa,
                                        logic [1:0] ab, logic da, logic db);
      ctrl_t c;
      c = '{db, da, ab, aa, 1'b0, s, m};
      return {18'h0, c};
   endfunction : ctrl

   // Counts the cycles in which each pin is high.
   task automatic measure(input int n, output int ha, output int hb);
      ha = 0;
      hb = 0;
      repeat (n) begin
         // Mid-cycle sampling sees the pins settled after the launching edge.
         @(negedge core_clk);
         if (pin_a === 1'b1) ha++;
         if (pin_b === 1'b1) hb++;
      end
   endtask : measure

   // Reset values, the spare bit and an unmapped address.
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rdchk("ctrl", OFS_CTRL, 32'h0);
      rdchk("count", OFS_COUNT, 32'h0);
      rdchk("flags", OFS_FLAGS, 32'h0);
      apb(1'b0, 8'h18, 32'h0, r, e);
      check("unmapped data", r, 32'h0);
      check("unmapped error", {31'h0, e}, 32'h1);
      wr(OFS_CTRL, 32'h0000_3f80);
      rdchk("spare bit", OFS_CTRL, 32'h0000_3f00);
      $display("test reset done");
   endtask : t_reset

   // Counter runs upward after reset: reads three cycles apart differ by three.
   task automatic t_direction();
      logic [31:0] c1, c2;
      logic e;
      wr(OFS_CTRL, ctrl(MODE_PC8, 3'h1, ACT_OFF, ACT_OFF, 1'b0, 1'b0));
      apb(1'b0, OFS_COUNT, 32'h0, c1, e);
      apb(1'b0, OFS_COUNT, 32'h0, c2, e);
      check("count step", c2 - c1, 32'h3);
      $display("test direction done");
   endtask : t_direction

   // Fixed TOP masks compare bits; a variable TOP mode keeps them.
   task automatic t_mask();
      logic [3:0] md[4] = '{MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP};
      logic [15:0] tp[4] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'hffff};
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL, ctrl(md[i], 3'h0, ACT_OFF, ACT_OFF, 1'b0, 1'b0));
         wr(OFS_CMPA, 32'h0000_ffff);
         wr(OFS_CMPB, 32'h0000_ffff);
         rdchk("cmpa mask", OFS_CMPA, {16'h0, tp[i]});
         rdchk("cmpb mask", OFS_CMPB, {16'h0, tp[i]});
      end
      $display("test mask done");
   endtask : t_mask

   // Phase-correct 8-bit duty: A non-inverted, B inverted, extremes included.
   task automatic t_duty();
      logic [15:0] v[3] = '{16'h0000, 16'h0040, 16'h00ff};
      int ha, hb;
      wr(OFS_CTRL, ctrl(MODE_PC8, 3'h1, ACT_NONINV, ACT_INV, 1'b1, 1'b1));
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CMPA, {16'h0, v[i]});
         wr(OFS_CMPB, {16'h0, v[i]});
         // A new compare loads at TOP and may act only from the TOP after that.
         repeat (1040) @(posedge core_clk);
         measure(510, ha, hb);
         check("a high", 32'(ha), 32'(2 * v[i]));
         check("b high", 32'(hb), 32'(510 - 2 * v[i]));
         check("a enable", {31'h0, oe_a}, 32'h1);
      end
      $display("test duty done");
   endtask : t_duty

   // Every prescaler divider, capture TOP of three (2-bit resolution).
   task automatic t_presc();
      int n[5] = '{1, 8, 64, 256, 1024};
      int ha, hb;
      wr(OFS_CAPTOP, 32'h0000_0003);
      wr(OFS_CMPA, 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL, ctrl(MODE_PC_CAP, 3'(i + 1), ACT_NONINV, ACT_OFF, 1'b1, 1'b1));
         // The first divider also waits for the counter to fall from the old TOP.
         repeat (12 * n[i] + 20 + ((i == 0) ? 520 : 0)) @(posedge core_clk);
         measure(6 * n[i], ha, hb);
         check("presc high", 32'(ha), 32'(2 * n[i]));
         check("b idle", 32'(hb), 32'h0);
      end
      $display("test prescaler done");
   endtask : t_presc

   // Mode 11 toggle on channel A, with TOP and bottom flags.
   task automatic t_toggle();
      int ha, hb;
      wr(OFS_CMPA, 32'h0000_0010);
      wr(OFS_CMPB, 32'h0000_0000);
      wr(OFS_CTRL, ctrl(MODE_PC_A, 3'h1, ACT_TOGGLE, ACT_OFF, 1'b1, 1'b0));
      repeat (80) @(posedge core_clk);
      wr(OFS_FLAGS, 32'h0000_000f);
      repeat (40) @(posedge core_clk);
      rdchk("pc flags", OFS_FLAGS, 32'h0000_0007);
      measure(64, ha, hb);
      check("toggle high", 32'(ha), 32'd32);
      $display("test toggle done");
   endtask : t_toggle

   // Phase-and-frequency-correct modes 8 and 9 on channel B.
   task automatic t_pfc();
      logic [3:0] md[2] = '{MODE_PFC_CAP, MODE_PFC_A};
      logic [31:0] fl[2] = '{32'h0000_000f, 32'h0000_0007};
      logic [15:0] bv[3] = '{16'h0000, 16'h0008, 16'h0020};
      int ha, hb;
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CAPTOP, 32'h0000_0020);
         wr(OFS_CMPA, 32'h0000_0020);
         wr(OFS_CMPB, 32'h0000_0008);
         wr(OFS_CTRL, ctrl(md[m], 3'h1, ACT_OFF, ACT_NONINV, 1'b0, 1'b1));
         repeat (150) @(posedge core_clk);
         wr(OFS_FLAGS, 32'h0000_000f);
         repeat (70) @(posedge core_clk);
         rdchk("pfc flags", OFS_FLAGS, fl[m]);
         for (int i = 0; i < 3; i++) begin
            wr(OFS_CMPB, {16'h0, bv[i]});
            // A new value loads at zero and acts from the next match on.
            repeat (140) @(posedge core_clk);
            measure(64, ha, hb);
            check("pfc b high", 32'(hb), 32'(2 * bv[i]));
         end
      end
      $display("test pfc done");
   endtask : t_pfc

   // Main sequence: two cycles of reset, then each scenario in turn.
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_direction();
      t_mask();
      t_duty();
      t_presc();
      t_toggle();
      t_pfc();
      finish_test();
   end
endmodule : dual_slope_pwm_timer16_bench

// ### testbench/pwm_load_model.sv
// Model of the power stage that listens to the two compare output pins.
module pwm_load_model (
   input wire logic drive_a,
   input wire logic oe_a,
   input wire logic drive_b,
   input wire logic oe_b,
   output logic pin_a,
   output logic pin_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // The stage input has a pull-down, so an undriven pin reads low.
   assign pin_a = oe_a ? drive_a : 1'b0;
   // Channel B sees the same pull-down when its driver is off.
   assign pin_b = oe_b ? drive_b : 1'b0;
endmodule : pwm_load_model
